// [rtl/plbdc_defines.vh]
// constants for the port loopback datapath control block
`ifndef PLBDC_DEFINES_VH
`define PLBDC_DEFINES_VH
// loopback selector codes
`define PLBDC_LB_NONE 2'h0
`define PLBDC_LB_FAC 2'h1
`define PLBDC_LB_TERM 2'h2
// card types
`define PLBDC_CARD_TXP 2'h0
`define PLBDC_CARD_MXP 2'h1
`define PLBDC_CARD_ADM 2'h2
// client traffic kinds
`define PLBDC_KIND_SONET 1'b0
`define PLBDC_KIND_GE 1'b1
// register byte offsets
`define PLBDC_OFF_CTRL 8'h00
`define PLBDC_OFF_STAT 8'h04
`define PLBDC_OFF_CFG 8'h08
// ctrl fields
`define PLBDC_CTRL_TRK_LSB 0
`define PLBDC_CTRL_CL0_LSB 2
`define PLBDC_CTRL_CL1_LSB 4
// cfg fields
`define PLBDC_CFG_CARD_LSB 0
`define PLBDC_CFG_KIND0 2
`define PLBDC_CFG_KIND1 3
`define PLBDC_CFG_ALMLB 4
// stat fields
`define PLBDC_ST_TERM_LSB 0
`define PLBDC_ST_FAC_LSB 3
`define PLBDC_ST_SUPP_LSB 6
`define PLBDC_ST_DEGR 9
// axi response codes
`define PLBDC_RESP_OK 2'h0
`define PLBDC_RESP_ERR 2'h2
// ais and idle patterns
`define PLBDC_AIS_WORD 32'hffff_ffff
`define PLBDC_IDLE_WORD 32'h0000_0000
`endif

// [rtl/plbdc_top.v]
// loopback datapath control for a two-client one-trunk line card
//
// Function
// - client terminal loop returns trunk traffic; here only client0, a client1 terminal loop turns nothing back up the trunk
// - trunk terminal loop returns client traffic
// - turnaround sits card side of interface
// - terminate or bridge fixed per card, role
// - terminated loop forwards nothing downstream
// - bridged loop also forwards downstream
// - ais downstream when terminated or on adm sonet client override
// - adm sonet client terminal loop sends ais
// - adm ge client terminal loop squelches
// - adm trunk facility loop ais sonet clients
// - adm trunk facility loop squelches ge clients
// - adm trunk terminal loop drop and continue
// - trunk terminal loop affects all clients
// - report terminal or facility loop condition
// - suppress alarms unless alarm-on-loop set
// - facility loop returns line input outward
`timescale 1ns/1ps
`default_nettype none
`include "plbdc_defines.vh"
// two clients share one trunk; client0 rides the trunk payload slot,
// client1 only receives the trunk drop in this two-client model
// software writes requested loop selectors into ctrl; each port copies
// its request at its own frame start so a switch never cuts a frame
// terminal loops turn the stream on the card side of the interface unit,
// facility loops return what the interface unit has just received
// every datapath output is one register stage behind its source
// management service states only raise trunk_loop_degraded; the block
// never refuses a loop request, since enforcing a state would need
// a handshake with management that this block does not have
module plbdc_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // port service states from management, same clock
  input wire trunk_in_service_normal_state,
  input wire [1:0] client_in_service_normal_state,
  // raw alarms per port: trunk, client0, client1
  input wire [2:0] port_alarm_raw,
  // frame starts per stream, same clock
  input wire trunk_frame_start,
  input wire [1:0] client_frame_start,
  // received words after line interface units
  input wire [31:0] trunk_rx_data,
  input wire [31:0] client0_rx_data,
  input wire [31:0] client1_rx_data,
  // words toward line interface units
  output reg [31:0] trunk_tx_data,
  output reg [31:0] client0_tx_data,
  output reg [31:0] client1_tx_data,
  // loop conditions and alarms per port
  output reg [2:0] terminal_loop_condition,
  output reg [2:0] facility_loop_condition,
  output reg [2:0] alarm_suppressed_maintenance,
  output reg [2:0] port_alarm_out,
  // loop not fully functional (trunk loop, clients not in service; txp client loop, trunk not in service)
  output reg trunk_loop_degraded
);

  // registers
  reg [5:0] ctrl_reg; // requested selectors
  reg [4:0] cfg_reg; // card type, kinds, alarm on loop
  reg [1:0] sel_trk_reg; // active selectors, frame aligned
  reg [1:0] sel_c0_reg;
  reg [1:0] sel_c1_reg;
  // write channel holding registers; each half waits for its partner
  reg [7:0] awaddr_reg; // captured write address
  reg aw_have_reg;
  reg [31:0] wdata_reg; // captured write data
  reg [3:0] wstrb_reg;
  reg w_have_reg;
  // next values from the combinational merge and read mux
  reg [5:0] ctrl_next;
  reg [4:0] cfg_next;
  reg [31:0] rdata_next;

  // decoded controls
  wire [1:0] card = cfg_reg[`PLBDC_CFG_CARD_LSB+1:`PLBDC_CFG_CARD_LSB];
  wire kind0 = cfg_reg[`PLBDC_CFG_KIND0];
  wire kind1 = cfg_reg[`PLBDC_CFG_KIND1];
  wire alm_on_loop = cfg_reg[`PLBDC_CFG_ALMLB];
  // adm is the only card with per-client ais and squelch overrides
  wire is_adm = (card == `PLBDC_CARD_ADM);

  // write channel: take address and data in either order
  // a held half refuses the next one until both meet, and a pending
  // response blocks both so a second write cannot overrun the answer
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  // one read outstanding: the address waits while read data stands
  assign s_axi_arready = !s_axi_rvalid;
  // both halves present: commit this cycle, answer on the next
  wire wr_go = aw_have_reg && w_have_reg;

  // byte merge of write data into ctrl and cfg
  always @* begin
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    // only byte lane 0 carries fields; upper lanes are ignored
    if (wr_go && wstrb_reg[0]) begin
      // unaligned or unmapped offsets never touch a register
      if (awaddr_reg == `PLBDC_OFF_CTRL)
        ctrl_next = wdata_reg[5:0];
      if (awaddr_reg == `PLBDC_OFF_CFG)
        cfg_next = wdata_reg[4:0];
    end
  end

  // write path sequencing and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLBDC_RESP_OK;
      ctrl_reg <= 6'h00;
      cfg_reg <= 5'h00;
    end else begin
      // registers take the merged value every cycle
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      // capture each half as it is offered
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      // data may arrive before or after its address
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (wr_go) begin
        // the three mapped words answer okay, others slverr
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg == `PLBDC_OFF_CTRL || awaddr_reg == `PLBDC_OFF_CFG ||
            awaddr_reg == `PLBDC_OFF_STAT)
          s_axi_bresp <= `PLBDC_RESP_OK;
        else
          s_axi_bresp <= `PLBDC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; stat shows live conditions
  always @* begin
    rdata_next = 32'h0000_0000;
    case (s_axi_araddr)
      `PLBDC_OFF_CTRL: rdata_next[5:0] = ctrl_reg;
      `PLBDC_OFF_CFG: rdata_next[4:0] = cfg_reg;
      // stat is read only; a write to it answers okay and changes nothing
      `PLBDC_OFF_STAT: begin
        rdata_next[`PLBDC_ST_TERM_LSB+2:`PLBDC_ST_TERM_LSB] = terminal_loop_condition;
        rdata_next[`PLBDC_ST_FAC_LSB+2:`PLBDC_ST_FAC_LSB] = facility_loop_condition;
        rdata_next[`PLBDC_ST_SUPP_LSB+2:`PLBDC_ST_SUPP_LSB] = alarm_suppressed_maintenance;
        rdata_next[`PLBDC_ST_DEGR] = trunk_loop_degraded;
      end
      // unmapped offsets read as zero
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read response, one cycle after address taken
  // arready drops while rvalid stands: half the read throughput,
  // traded for a single read data register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PLBDC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      if (s_axi_araddr == `PLBDC_OFF_CTRL || s_axi_araddr == `PLBDC_OFF_CFG ||
          s_axi_araddr == `PLBDC_OFF_STAT)
        s_axi_rresp <= `PLBDC_RESP_OK;
      else
        s_axi_rresp <= `PLBDC_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // selectors follow requests only at frame starts, avoiding partial frames
  // a request written mid-frame waits up to one frame period
  // before it reaches the datapath and the condition outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_trk_reg <= `PLBDC_LB_NONE;
      sel_c0_reg <= `PLBDC_LB_NONE;
      sel_c1_reg <= `PLBDC_LB_NONE;
    end else begin
      if (trunk_frame_start)
        sel_trk_reg <= ctrl_reg[`PLBDC_CTRL_TRK_LSB+1:`PLBDC_CTRL_TRK_LSB];
      if (client_frame_start[0])
        sel_c0_reg <= ctrl_reg[`PLBDC_CTRL_CL0_LSB+1:`PLBDC_CTRL_CL0_LSB];
      if (client_frame_start[1])
        sel_c1_reg <= ctrl_reg[`PLBDC_CTRL_CL1_LSB+1:`PLBDC_CTRL_CL1_LSB];
    end
  end

  // loop kinds per port
  // the spare selector code decodes to no loop at all
  // facility and terminal are exclusive by encoding
  wire trk_term = (sel_trk_reg == `PLBDC_LB_TERM);
  wire trk_fac = (sel_trk_reg == `PLBDC_LB_FAC);
  wire c0_term = (sel_c0_reg == `PLBDC_LB_TERM);
  wire c0_fac = (sel_c0_reg == `PLBDC_LB_FAC);
  wire c1_term = (sel_c1_reg == `PLBDC_LB_TERM);
  wire c1_fac = (sel_c1_reg == `PLBDC_LB_FAC);

  // terminal loops all bridge on every card and role; facility loops
  // terminate on the trunk and bridge on adm/mxp clients, terminate on txp clients
  // bridging is fixed per card and role, never software settable
  wire term_bridges = 1'b1;
  wire trk_fac_bridges = 1'b0;
  wire cl_fac_bridges = (card != `PLBDC_CARD_TXP);
  // downstream is terminated when the loop does not bridge
  wire trk_cut = (trk_term && !term_bridges) || (trk_fac && !trk_fac_bridges);
  wire c0_cut = (c0_term && !term_bridges) || (c0_fac && !cl_fac_bridges);
  wire c1_cut = (c1_term && !term_bridges) || (c1_fac && !cl_fac_bridges);

  // client0 output: adm ais/squelch overrides, else loop or trunk drop
  // a trunk facility loop reaches every adm client of its kind
  // a client has one kind at a time, so ais and squelch never meet
  wire c0_ais = is_adm && kind0 == `PLBDC_KIND_SONET && (c0_term || trk_fac);
  wire c0_sq = is_adm && kind0 == `PLBDC_KIND_GE && (c0_term || trk_fac);
  wire c1_ais = is_adm && kind1 == `PLBDC_KIND_SONET && (c1_term || trk_fac);
  wire c1_sq = is_adm && kind1 == `PLBDC_KIND_GE && (c1_term || trk_fac);

  // datapath: terminal turns before the unit, facility turns after it
  always @(posedge aclk) begin
    if (!aresetn) begin
      trunk_tx_data <= `PLBDC_IDLE_WORD;
      client0_tx_data <= `PLBDC_IDLE_WORD;
      client1_tx_data <= `PLBDC_IDLE_WORD;
    end else begin
      // trunk output: client0 word, a trunk facility or client0 terminal loop replaces it
      // priority: trunk facility, client0 terminal, client0 cut, normal
      if (trk_fac)
        trunk_tx_data <= trunk_rx_data;
      else if (c0_term)
        trunk_tx_data <= trunk_rx_data;
      else if (c0_cut)
        trunk_tx_data <= `PLBDC_AIS_WORD;
      else
        trunk_tx_data <= client0_rx_data;
      // client0 output
      // priority: adm overrides, own facility, trunk terminal, trunk cut
      if (c0_sq)
        client0_tx_data <= `PLBDC_IDLE_WORD;
      else if (c0_ais)
        client0_tx_data <= `PLBDC_AIS_WORD;
      else if (c0_fac)
        client0_tx_data <= client0_rx_data;
      else if (trk_term)
        client0_tx_data <= client0_rx_data;
      else if (trk_cut)
        client0_tx_data <= `PLBDC_AIS_WORD;
      else
        client0_tx_data <= trunk_rx_data;
      // client1 output
      // mirrors client0 but is never carried up the trunk
      if (c1_sq)
        client1_tx_data <= `PLBDC_IDLE_WORD;
      else if (c1_ais)
        client1_tx_data <= `PLBDC_AIS_WORD;
      else if (c1_fac)
        client1_tx_data <= client1_rx_data;
      else if (trk_term)
        client1_tx_data <= client1_rx_data;
      else if (trk_cut)
        client1_tx_data <= `PLBDC_AIS_WORD;
      else
        client1_tx_data <= trunk_rx_data;
    end
  end

  // conditions and alarm suppression per port
  // conditions follow the active selectors, not the requests, so
  // software sees a loop only once the datapath has switched
  always @(posedge aclk) begin
    if (!aresetn) begin
      terminal_loop_condition <= 3'h0;
      facility_loop_condition <= 3'h0;
      alarm_suppressed_maintenance <= 3'h0;
      port_alarm_out <= 3'h0;
      trunk_loop_degraded <= 1'b0;
    end else begin
      terminal_loop_condition <= {c1_term, c0_term, trk_term};
      facility_loop_condition <= {c1_fac, c0_fac, trk_fac};
      alarm_suppressed_maintenance <=
        {c1_term | c1_fac, c0_term | c0_fac, trk_term | trk_fac};
      // looped ports hide raw alarms unless alarm on loop is set
      if (alm_on_loop)
        port_alarm_out <= port_alarm_raw;
      else
        port_alarm_out <= port_alarm_raw &
          ~{c1_term | c1_fac, c0_term | c0_fac, trk_term | trk_fac};
      // management duty only; flagged, not enforced
      // a trunk terminal loop with a client out of service, or a txp
      // client terminal loop with the trunk out of service
      trunk_loop_degraded <= trk_term && !(&client_in_service_normal_state) ||
        ((c0_term || c1_term) && card == `PLBDC_CARD_TXP &&
         !trunk_in_service_normal_state);
    end
  end

endmodule
`default_nettype wire

// [tb/plbdc_asserts.sv]
// port-level checks for the loopback control block
`timescale 1ns/1ps
`default_nettype none
module plbdc_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // trunk stream
  input wire logic trunk_frame_start,
  input wire logic [31:0] trunk_rx_data,
  input wire logic [31:0] trunk_tx_data,
  // conditions and alarms
  input wire logic [2:0] terminal_loop_condition,
  input wire logic [2:0] facility_loop_condition,
  input wire logic [2:0] port_alarm_raw,
  input wire logic [2:0] port_alarm_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken in one beat
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // selector latched on a trunk frame start
  sequence s_trunk_frame;
    trunk_frame_start ##2 1'b1;
  endsequence
  a_wr_resp_time: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rd_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_cond_exclusive: assert property ((terminal_loop_condition & facility_loop_condition) == 3'h0)
    else $error("both loop conditions on one port");
  a_alarm_cause: assert property ((port_alarm_out & ~$past(port_alarm_raw)) == 3'h0)
    else $error("alarm out without raw alarm");
  a_term_at_frame: assert property ($rose(terminal_loop_condition[0]) |-> $past(trunk_frame_start, 2))
    else $error("trunk loop switched off frame boundary");
  a_client_turn: assert property (terminal_loop_condition == 3'b010 && facility_loop_condition == 3'h0 |-> trunk_tx_data == $past(trunk_rx_data))
    else $error("client loop not turned to trunk");
  c_trunk_frame: cover property (s_trunk_frame);
endmodule
`default_nettype wire

// [tb/plbdc_span_model.sv]
// far-side span model: frame markers and ever-changing words
`timescale 1ns/1ps
`default_nettype none
module plbdc_span_model (
  // bench clock
  input wire logic aclk,
  // frame markers
  output var logic trunk_frame_start,
  output var logic [1:0] client_frame_start,
  // received words
  output var logic [31:0] trunk_rx_data,
  output var logic [31:0] client0_rx_data,
  output var logic [31:0] client1_rx_data
);
  logic [7:0] cnt_reg = 8'h00;
  // new word each cycle so a stuck path never matches by luck
  always @(posedge aclk) begin
    cnt_reg <= cnt_reg + 8'h01;
    trunk_rx_data <= {24'h71_7171, cnt_reg};
    client0_rx_data <= {24'h30_3030, ~cnt_reg};
    client1_rx_data <= {24'h5a_5a5a, cnt_reg};
    trunk_frame_start <= cnt_reg[2:0] == 3'h0;
    client_frame_start <= {2{cnt_reg[2:0] == 3'h4}};
  end
endmodule
`default_nettype wire

// [tb/plbdc_top_tb_top.sv]
// self-checking bench for the loopback control block
`timescale 1ns/1ps
`default_nettype none
`include "plbdc_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module plbdc_top_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic trunk_in_service_normal_state = 1'b1;
  logic [1:0] client_in_service_normal_state = 2'h3;
  logic [2:0] port_alarm_raw = 3'h0;
  logic trunk_frame_start, trunk_loop_degraded;
  logic [1:0] client_frame_start;
  logic [31:0] trunk_rx_data, client0_rx_data, client1_rx_data, tp, c0p, c1p;
  logic [31:0] trunk_tx_data, client0_tx_data, client1_tx_data;
  logic [2:0] terminal_loop_condition, facility_loop_condition;
  logic [2:0] alarm_suppressed_maintenance, port_alarm_out;
  int checks = 0, mismatches = 0;
  plbdc_top dut (.*);
  plbdc_span_model span (.*);
  initial forever #2.5 aclk = ~aclk;
  // words one cycle old, matching the tx latency
  always @(posedge aclk) begin
    tp <= trunk_rx_data;
    c0p <= client0_rx_data;
    c1p <= client1_rx_data;
  end
  // write: hold each half until taken, then wait for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end while (!b);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, r)
  endtask
  // read: hold the address until taken, take data with rvalid
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    ar = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      if (s_axi_arready) ar = 1'b0;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_arvalid <= ar;
    end while (!v);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, d)
    `CHK("rresp", er, r)
  endtask
  // spans more than one frame period of every stream
  task automatic settle;
    repeat (20) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PLBDC_OFF_CTRL, 32'h0000_0000, `PLBDC_RESP_OK);
    rd(`PLBDC_OFF_STAT, 32'h0000_0000, `PLBDC_RESP_OK);
    rd(8'h40, 32'h0000_0000, `PLBDC_RESP_ERR);
    wr(8'h40, 32'h0000_0003, `PLBDC_RESP_ERR);
    settle;
    `CHK("trunk_tx", c0p, trunk_tx_data)
    `CHK("client0_tx", tp, client0_tx_data)
    $display("test reset_and_idle done");
    wr(`PLBDC_OFF_CTRL, 32'h0000_0008, `PLBDC_RESP_OK);
    port_alarm_raw <= 3'h7;
    settle;
    `CHK("terminal", 3'b010, terminal_loop_condition)
    `CHK("trunk_tx", tp, trunk_tx_data)
    `CHK("client0_tx", tp, client0_tx_data)
    `CHK("suppressed", 3'b010, alarm_suppressed_maintenance)
    `CHK("alarm_out", 3'b101, port_alarm_out)
    rd(`PLBDC_OFF_STAT, 32'h0000_0082, `PLBDC_RESP_OK);
    wr(`PLBDC_OFF_CFG, 32'h0000_0010, `PLBDC_RESP_OK);
    settle;
    `CHK("alarm_out", 3'h7, port_alarm_out)
    $display("test client_terminal done");
    wr(`PLBDC_OFF_CTRL, 32'h0000_0002, `PLBDC_RESP_OK);
    settle;
    `CHK("client0_tx", c0p, client0_tx_data)
    `CHK("client1_tx", c1p, client1_tx_data)
    `CHK("trunk_tx", c0p, trunk_tx_data)
    `CHK("degraded", 1'b0, trunk_loop_degraded)
    @(posedge aclk);
    client_in_service_normal_state <= 2'h1;
    settle;
    `CHK("degraded", 1'b1, trunk_loop_degraded)
    $display("test trunk_terminal done");
    wr(`PLBDC_OFF_CTRL, 32'h0000_0001, `PLBDC_RESP_OK);
    settle;
    `CHK("facility", 3'b001, facility_loop_condition)
    `CHK("trunk_tx", tp, trunk_tx_data)
    `CHK("client0_tx", `PLBDC_AIS_WORD, client0_tx_data)
    wr(`PLBDC_OFF_CFG, 32'h0000_0006, `PLBDC_RESP_OK);
    settle;
    `CHK("client0_tx", `PLBDC_IDLE_WORD, client0_tx_data)
    `CHK("client1_tx", `PLBDC_AIS_WORD, client1_tx_data)
    wr(`PLBDC_OFF_CTRL, 32'h0000_0028, `PLBDC_RESP_OK);
    settle;
    `CHK("client0_tx", `PLBDC_IDLE_WORD, client0_tx_data)
    `CHK("client1_tx", `PLBDC_AIS_WORD, client1_tx_data)
    wr(`PLBDC_OFF_CTRL, 32'h0000_0002, `PLBDC_RESP_OK);
    settle;
    `CHK("trunk_tx", c0p, trunk_tx_data)
    $display("test adm_card done");
    wr(`PLBDC_OFF_CFG, 32'h0000_0000, `PLBDC_RESP_OK);
    wr(`PLBDC_OFF_CTRL, 32'h0000_0004, `PLBDC_RESP_OK);
    settle;
    `CHK("facility", 3'b010, facility_loop_condition)
    `CHK("client0_tx", c0p, client0_tx_data)
    `CHK("trunk_tx", `PLBDC_AIS_WORD, trunk_tx_data)
    wr(`PLBDC_OFF_CFG, 32'h0000_0001, `PLBDC_RESP_OK);
    settle;
    `CHK("trunk_tx", c0p, trunk_tx_data)
    wr(`PLBDC_OFF_CTRL, 32'h0000_0008, `PLBDC_RESP_OK);
    trunk_in_service_normal_state <= 1'b0;
    settle;
    `CHK("degraded", 1'b0, trunk_loop_degraded)
    wr(`PLBDC_OFF_CFG, 32'h0000_0000, `PLBDC_RESP_OK);
    settle;
    `CHK("degraded", 1'b1, trunk_loop_degraded)
    @(posedge aclk);
    trunk_in_service_normal_state <= 1'b1;
    settle;
    `CHK("degraded", 1'b0, trunk_loop_degraded)
    $display("test client_facility_and_states done");
    tally_and_finish;
  end
  // hang guard, well past the few hundred cycles the tests take
  initial begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    tally_and_finish;
  end
endmodule
bind plbdc_top plbdc_asserts chk (.*);
`default_nettype wire
